// [hw/pcv_config_status.v]
// Configuration and status vector register bank of a 10G PCS/PMA.
`timescale 1ns/10ps
`include "pcv_defs.vh"

module pcv_config_status #(
    parameter ERRB_W = 8,
    parameter BERC_W = 6,
    parameter TPE_W  = 16,
    parameter FEC_W  = 32
) (
    input  wire                    clk,
    input  wire                    rst_n,
    input  wire [`PCV_CFG_W-1:0]   configVector,
    input  wire                    pmaLinkUp,
    input  wire                    pmaRxFault,
    input  wire                    pmaTxFault,
    input  wire                    sigDetect,
    input  wire                    pmaResetBusy,
    input  wire                    pcsResetBusy,
    input  wire                    pcsLinkUp,
    input  wire                    pcsRxFault,
    input  wire                    pcsTxFault,
    input  wire                    blockLock,
    input  wire                    highBer,
    input  wire                    rxLinkUp,
    input  wire                    erroredBlockEvt,
    input  wire                    berEvt,
    input  wire                    testPatErrEvt,
    input  wire                    fecCorrEvt,
    input  wire                    fecUncorrEvt,
    input  wire                    anResetBusy,
    input  wire                    anLinkUp,
    input  wire                    anRemoteFault,
    input  wire                    anComplete,
    input  wire                    anPageRx,
    input  wire                    krNegotiated,
    input  wire                    fecNegotiated,
    output reg  [`PCV_STS_W-1:0]   statusVector,
    output reg  [`PCV_ADV_W-1:0]   anAdvPage,
    output reg  [`PCV_XNP_W-1:0]   anXnpPage,
    output reg  [5:0]              lpCoeffUpdate,
    output reg                     lpCoeffInit,
    output reg                     lpCoeffPreset
);

// ----------------------------------------------------------------------
// Reset synchroniser
// ----------------------------------------------------------------------
reg rstMeta_reg;
reg rstSync_reg;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rstMeta_reg <= 1'b0;
        rstSync_reg <= 1'b0;
    end else begin
        rstMeta_reg <= 1'b1;
        rstSync_reg <= rstMeta_reg;
    end
end

// ----------------------------------------------------------------------
// Latched flags and counters
// ----------------------------------------------------------------------
// Controls are pulses of one cycle; a longer pulse simply holds the set or clear.
wire setPma  = configVector[`PCV_CFG_SET_PMA];
wire setPcs  = configVector[`PCV_CFG_SET_PCS];
wire clrSt2  = configVector[`PCV_CFG_CLR_ST2];
wire clrPmaF = configVector[`PCV_CFG_CLR_PMAF];
wire clrPcsF = configVector[`PCV_CFG_CLR_PCSF];
wire clrTpe  = configVector[`PCV_CFG_CLR_TPE];
wire clrFecC = configVector[`PCV_CFG_CLR_FECC];
wire clrFecU = configVector[`PCV_CFG_CLR_FECU];
wire setAnl  = configVector[`PCV_CFG_SET_ANL];
wire clrAnRf = configVector[`PCV_CFG_CLR_ANRF];
wire clrAnPr = configVector[`PCV_CFG_CLR_ANPR];

reg              llPmaLink_reg;
reg              llPcsLink_reg;
reg              llLock_reg;
reg              llAnLink_reg;
reg              lhBer_reg;
reg              lhPmaRx_reg;
reg              lhPmaTx_reg;
reg              lhPcsRx_reg;
reg              lhPcsTx_reg;
reg              lhAnRf_reg;
reg              lhAnPr_reg;
reg [ERRB_W-1:0] errb_reg;
reg [BERC_W-1:0] berc_reg;
reg [TPE_W-1:0]  tpe_reg;
reg [FEC_W-1:0]  fecC_reg;
reg [FEC_W-1:0]  fecU_reg;
reg              ldAdvPrev_reg;
reg              ldXnpPrev_reg;

// Counters saturate rather than wrap so a stale read never looks healthy.
always @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
        llPmaLink_reg <= 1'b1;
        llPcsLink_reg <= 1'b1;
        llLock_reg    <= 1'b1;
        llAnLink_reg  <= 1'b1;
        lhBer_reg     <= 1'b0;
        lhPmaRx_reg   <= 1'b0;
        lhPmaTx_reg   <= 1'b0;
        lhPcsRx_reg   <= 1'b0;
        lhPcsTx_reg   <= 1'b0;
        lhAnRf_reg    <= 1'b0;
        lhAnPr_reg    <= 1'b0;
        ldAdvPrev_reg <= 1'b0;
        ldXnpPrev_reg <= 1'b0;
    end else begin
        // A false condition wins over a set pulse, so no drop is lost.
        llPmaLink_reg <= pmaLinkUp & (llPmaLink_reg | setPma);
        llPcsLink_reg <= pcsLinkUp & (llPcsLink_reg | setPcs);
        llLock_reg    <= blockLock & (llLock_reg | clrSt2);
        llAnLink_reg  <= anLinkUp & (llAnLink_reg | setAnl);
        lhBer_reg     <= highBer | (lhBer_reg & ~clrSt2);
        lhPmaRx_reg   <= pmaRxFault | (lhPmaRx_reg & ~clrPmaF);
        lhPmaTx_reg   <= pmaTxFault | (lhPmaTx_reg & ~clrPmaF);
        lhPcsRx_reg   <= pcsRxFault | (lhPcsRx_reg & ~clrPcsF);
        lhPcsTx_reg   <= pcsTxFault | (lhPcsTx_reg & ~clrPcsF);
        lhAnRf_reg    <= anRemoteFault | (lhAnRf_reg & ~clrAnRf);
        lhAnPr_reg    <= anPageRx | (lhAnPr_reg & ~clrAnPr);
        ldAdvPrev_reg <= configVector[`PCV_CFG_LD_ADV];
        ldXnpPrev_reg <= configVector[`PCV_CFG_LD_XNP];
    end
end

// ----------------------------------------------------------------------
// Event counters
// ----------------------------------------------------------------------
// A clear in the same cycle as an event wins, so no count survives a clear.
always @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
        errb_reg <= {ERRB_W{1'b0}};
    end else if (clrSt2) begin
        errb_reg <= {ERRB_W{1'b0}};
    end else if (erroredBlockEvt && errb_reg != {ERRB_W{1'b1}}) begin
        errb_reg <= errb_reg + {{(ERRB_W-1){1'b0}}, 1'b1};
    end
end

always @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
        berc_reg <= {BERC_W{1'b0}};
    end else if (clrSt2) begin
        berc_reg <= {BERC_W{1'b0}};
    end else if (berEvt && berc_reg != {BERC_W{1'b1}}) begin
        berc_reg <= berc_reg + {{(BERC_W-1){1'b0}}, 1'b1};
    end
end

always @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
        tpe_reg <= {TPE_W{1'b0}};
    end else if (clrTpe) begin
        tpe_reg <= {TPE_W{1'b0}};
    end else if (testPatErrEvt && tpe_reg != {TPE_W{1'b1}}) begin
        tpe_reg <= tpe_reg + {{(TPE_W-1){1'b0}}, 1'b1};
    end
end

always @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
        fecC_reg <= {FEC_W{1'b0}};
    end else if (clrFecC) begin
        fecC_reg <= {FEC_W{1'b0}};
    end else if (fecCorrEvt && fecC_reg != {FEC_W{1'b1}}) begin
        fecC_reg <= fecC_reg + {{(FEC_W-1){1'b0}}, 1'b1};
    end
end

always @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
        fecU_reg <= {FEC_W{1'b0}};
    end else if (clrFecU) begin
        fecU_reg <= {FEC_W{1'b0}};
    end else if (fecUncorrEvt && fecU_reg != {FEC_W{1'b1}}) begin
        fecU_reg <= fecU_reg + {{(FEC_W-1){1'b0}}, 1'b1};
    end
end

// ----------------------------------------------------------------------
// Page capture and training controls
// ----------------------------------------------------------------------
wire ldAdv = configVector[`PCV_CFG_LD_ADV] & ~ldAdvPrev_reg;
wire ldXnp = configVector[`PCV_CFG_LD_XNP] & ~ldXnpPrev_reg;
wire trnOff = ~configVector[`PCV_CFG_TRN_EN];

// Pages load on an edge only, keeping the three words of each page coherent.
always @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
        anAdvPage     <= {`PCV_ADV_W{1'b0}};
        anXnpPage     <= {`PCV_XNP_W{1'b0}};
        lpCoeffUpdate <= 6'h00;
        lpCoeffInit   <= 1'b0;
        lpCoeffPreset <= 1'b0;
    end else begin
        if (ldAdv) begin
            anAdvPage <= configVector[`PCV_CFG_ADV_HI:`PCV_CFG_ADV_LO];
        end
        if (ldXnp) begin
            anXnpPage <= configVector[`PCV_CFG_XNP_HI:`PCV_CFG_XNP_LO];
        end
        lpCoeffUpdate <= configVector[`PCV_CFG_LPC_HI:`PCV_CFG_LPC_LO];
        lpCoeffInit   <= configVector[`PCV_CFG_LPC_INIT] & trnOff;
        lpCoeffPreset <= configVector[`PCV_CFG_LPC_PRE] & trnOff;
    end
end

// ----------------------------------------------------------------------
// Status vector assembly
// ----------------------------------------------------------------------
reg [`PCV_STS_W-1:0] status_next;
always @* begin
    status_next = {`PCV_STS_W{1'b0}};
    status_next[`PCV_STS_PMA_RST]  = pmaResetBusy;
    status_next[`PCV_STS_PMA_LINK] = llPmaLink_reg;
    status_next[`PCV_STS_PMA_RXF]  = lhPmaRx_reg;
    status_next[`PCV_STS_PMA_TXF]  = lhPmaTx_reg;
    status_next[`PCV_STS_PMA_FLT]  = lhPmaRx_reg | lhPmaTx_reg;
    status_next[`PCV_STS_SIGDET]   = sigDetect;
    status_next[`PCV_STS_LPC_HI:`PCV_STS_LPC_LO] = lpCoeffUpdate;
    status_next[`PCV_STS_LPC_INIT] = lpCoeffInit;
    status_next[`PCV_STS_LPC_PRE]  = lpCoeffPreset;
    status_next[`PCV_STS_FECC_HI:`PCV_STS_FECC_LO] = fecC_reg;
    status_next[`PCV_STS_FECU_HI:`PCV_STS_FECU_LO] = fecU_reg;
    status_next[`PCV_STS_PCS_RST]  = pcsResetBusy;
    status_next[`PCV_STS_PCS_LINK] = llPcsLink_reg;
    status_next[`PCV_STS_PCS_RXF]  = lhPcsRx_reg;
    status_next[`PCV_STS_PCS_TXF]  = lhPcsTx_reg;
    status_next[`PCV_STS_PCS_FLT]  = lhPcsRx_reg | lhPcsTx_reg;
    status_next[`PCV_STS_BLK_LOCK] = blockLock;
    status_next[`PCV_STS_HI_BER]   = highBer;
    status_next[`PCV_STS_RX_LINK]  = rxLinkUp;
    status_next[`PCV_STS_ERRB_HI:`PCV_STS_ERRB_LO] = errb_reg;
    status_next[`PCV_STS_BERC_HI:`PCV_STS_BERC_LO] = berc_reg;
    status_next[`PCV_STS_LH_BER]   = lhBer_reg;
    status_next[`PCV_STS_LL_LOCK]  = llLock_reg;
    status_next[`PCV_STS_TPE_HI:`PCV_STS_TPE_LO] = tpe_reg;
    status_next[`PCV_STS_AN_RST]   = anResetBusy;
    status_next[`PCV_STS_AN_LINK]  = llAnLink_reg;
    status_next[`PCV_STS_AN_RF]    = lhAnRf_reg;
    status_next[`PCV_STS_AN_CMPL]  = anComplete;
    status_next[`PCV_STS_AN_PR]    = lhAnPr_reg;
    status_next[`PCV_STS_KR_NEG]   = krNegotiated;
    status_next[`PCV_STS_FEC_NEG]  = fecNegotiated;
end

// The vector is registered, so every field lags its source by one cycle.
always @(posedge clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
        statusVector <= {`PCV_STS_W{1'b0}};
    end else begin
        statusVector <= status_next;
    end
end

endmodule // pcv_config_status

// [hw/pcv_defs.vh]
// Bit positions and field layout of the configuration and status vectors.
`ifndef PCV_DEFS_VH
`define PCV_DEFS_VH
`define PCV_CFG_W          536
`define PCV_STS_W          448
`define PCV_CFG_PMA_LBK    0
`define PCV_CFG_PMA_RST    15
`define PCV_CFG_TRN_EN     33
`define PCV_CFG_LPC_LO     48
`define PCV_CFG_LPC_HI     53
`define PCV_CFG_LPC_INIT   60
`define PCV_CFG_LPC_PRE    61
`define PCV_CFG_FEC_EN     64
`define PCV_CFG_FEC_ERR    65
`define PCV_CFG_PCS_RST    111
`define PCV_CFG_AN_RST     287
`define PCV_CFG_ADV_LO     293
`define PCV_CFG_ADV_HI     335
`define PCV_CFG_XNP_LO     336
`define PCV_CFG_XNP_HI     383
`define PCV_CFG_SET_PMA    512
`define PCV_CFG_CLR_PMAF   513
`define PCV_CFG_CLR_FECC   514
`define PCV_CFG_CLR_FECU   515
`define PCV_CFG_SET_PCS    516
`define PCV_CFG_CLR_PCSF   517
`define PCV_CFG_CLR_ST2    518
`define PCV_CFG_CLR_TPE    519
`define PCV_CFG_SET_ANL    520
`define PCV_CFG_CLR_ANRF   521
`define PCV_CFG_CLR_ANPR   522
`define PCV_CFG_LD_ADV     523
`define PCV_CFG_LD_XNP     524
`define PCV_STS_PMA_RST    15
`define PCV_STS_PMA_LINK   18
`define PCV_STS_PMA_FLT    23
`define PCV_STS_PMA_RXF    42
`define PCV_STS_PMA_TXF    43
`define PCV_STS_SIGDET     48
`define PCV_STS_LPC_LO     96
`define PCV_STS_LPC_HI     101
`define PCV_STS_LPC_INIT   108
`define PCV_STS_LPC_PRE    109
`define PCV_STS_FECC_LO    128
`define PCV_STS_FECC_HI    159
`define PCV_STS_FECU_LO    160
`define PCV_STS_FECU_HI    191
`define PCV_STS_PCS_RST    223
`define PCV_STS_PCS_LINK   226
`define PCV_STS_PCS_FLT    231
`define PCV_STS_PCS_RXF    250
`define PCV_STS_PCS_TXF    251
`define PCV_STS_BLK_LOCK   256
`define PCV_STS_HI_BER     257
`define PCV_STS_RX_LINK    268
`define PCV_STS_ERRB_LO    272
`define PCV_STS_ERRB_HI    279
`define PCV_STS_BERC_LO    280
`define PCV_STS_BERC_HI    285
`define PCV_STS_LH_BER     286
`define PCV_STS_LL_LOCK    287
`define PCV_STS_TPE_LO     288
`define PCV_STS_TPE_HI     303
`define PCV_STS_AN_RST     319
`define PCV_STS_AN_LINK    322
`define PCV_STS_AN_RF      324
`define PCV_STS_AN_CMPL    325
`define PCV_STS_AN_PR      326
`define PCV_STS_KR_NEG     435
`define PCV_STS_FEC_NEG    436
`define PCV_ADV_W          43
`define PCV_XNP_W          48
`endif

// [tb/pcv_user_model.sv]
// Model of the user logic that drives the configuration vector.
`timescale 1ns/10ps
`include "pcv_defs.vh"
module pcv_user_model (
    input  wire                  clk,
    output reg [`PCV_CFG_W-1:0]  configVector
);
    // --------
    // Control
    // --------
    // Only named fields are ever written, so spare bits stay zero.
    initial configVector = {`PCV_CFG_W{1'h0}};
    // A held control would keep clearing, so each one lasts one cycle.
    task pulse(input integer b);
        @(negedge clk) configVector[b] = 1'h1;
        @(negedge clk) configVector[b] = 1'h0;
    endtask
    task put(input integer lo, input integer w, input [47:0] v);
        integer j;
        for (j = 0; j < w; j = j + 1) configVector[lo + j] = v[j];
    endtask
endmodule // pcv_user_model

// [tb/pcv_config_status_sva.sv]
// Checker of the configuration and status vector bank.
`timescale 1ns/10ps
`include "pcv_defs.vh"
module pcv_config_status_sva (
    input wire                   clk,
    input wire                   rst_n,
    input wire [`PCV_CFG_W-1:0]  configVector,
    input wire                   pmaLinkUp,
    input wire                   highBer,
    input wire                   pcsRxFault,
    input wire                   pcsTxFault,
    input wire                   rxLinkUp,
    input wire                   krNegotiated,
    input wire [`PCV_STS_W-1:0]  statusVector,
    input wire [`PCV_ADV_W-1:0]  anAdvPage,
    input wire                   lpCoeffInit,
    input wire                   lpCoeffPreset
);
    // --------
    // Checks
    // --------
    // The bank leaves reset two edges late, so checking waits three.
    reg  [2:0] upPipe_reg;
    wire       ready = upPipe_reg[2];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) upPipe_reg <= 3'h0;
        else upPipe_reg <= {upPipe_reg[1:0], 1'h1};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!ready);
    chk_pma_set: assert property (configVector[512] && pmaLinkUp
        |-> ##2 statusVector[18]) else $error("PMA link flag not set.");
    chk_pma_drop: assert property (!pmaLinkUp
        |-> ##2 !statusVector[18]) else $error("PMA link flag not low.");
    chk_ber_hold: assert property (highBer
        |-> ##2 statusVector[286]) else $error("BER flag not set.");
    chk_ber_clr: assert property (configVector[518] && !highBer
        |-> ##2 !statusVector[286]) else $error("BER flag not cleared.");
    chk_pcs_clr: assert property (configVector[517] && !pcsRxFault && !pcsTxFault
        |-> ##2 !statusVector[250] && !statusVector[251]) else $error("PCS fault kept.");
    chk_fault_sum: assert property (statusVector[23] == (statusVector[42] | statusVector[43])
        && statusVector[231] == (statusVector[250] | statusVector[251]))
        else $error("Fault summary wrong.");
    chk_errb_clr: assert property (configVector[518]
        |-> ##2 statusVector[285:272] == 14'h0) else $error("Status-2 counters kept.");
    chk_tpe_clr: assert property (configVector[519]
        |-> ##2 statusVector[303:288] == 16'h0) else $error("Pattern counter kept.");
    chk_fecc_clr: assert property (configVector[514]
        |-> ##2 statusVector[159:128] == 32'h0) else $error("Corrected count kept.");
    chk_fecu_clr: assert property (configVector[515]
        |-> ##2 statusVector[191:160] == 32'h0) else $error("Uncorrected count kept.");
    chk_adv_load: assert property ($rose(configVector[523])
        |=> anAdvPage == $past(configVector[335:293])) else $error("Page not loaded.");
    chk_adv_hold: assert property (!$rose(configVector[523])
        |=> $stable(anAdvPage)) else $error("Page changed without load.");
    chk_lpc_gate: assert property (configVector[33]
        |=> !lpCoeffInit && !lpCoeffPreset) else $error("Coefficient control leaked.");
    chk_live_bits: assert property (statusVector[268] == $past(rxLinkUp)
        && statusVector[435] == $past(krNegotiated)) else $error("Live bit wrong.");
    cover property (configVector[512] && pmaLinkUp);
    cover property ($rose(configVector[524]));
    cover property (configVector[518] && statusVector[286]);
endmodule // pcv_config_status_sva

bind pcv_config_status pcv_config_status_sva chk_u (.clk(clk), .rst_n(rst_n),
    .configVector(configVector), .pmaLinkUp(pmaLinkUp), .highBer(highBer),
    .pcsRxFault(pcsRxFault), .pcsTxFault(pcsTxFault), .rxLinkUp(rxLinkUp),
    .krNegotiated(krNegotiated), .statusVector(statusVector), .anAdvPage(anAdvPage),
    .lpCoeffInit(lpCoeffInit), .lpCoeffPreset(lpCoeffPreset));

// [tb/testbench.sv]
// Self-checking bench of the configuration and status vector bank.
`timescale 1ns/10ps
`include "pcv_defs.vh"
module testbench;
    // --------
    // Setup
    // --------
    reg                    clk;
    reg                    rst_n;
    reg  [3:0]             lowIn;
    reg  [6:0]             hiIn;
    reg  [4:0]             evt;
    reg  [7:0]             lvl;
    reg  [47:0]            pg;
    wire [`PCV_CFG_W-1:0]  cfg;
    wire [`PCV_STS_W-1:0]  sts;
    wire [`PCV_ADV_W-1:0]  adv;
    wire [`PCV_XNP_W-1:0]  xnp;
    wire [5:0]             lpcUpd;
    wire                   lpcInit;
    wire                   lpcPre;
    integer n_mismatch = 0;
    integer n_tests = 0;
    integer i, n;
    int lowPos[4] = '{18, 226, 287, 322};
    int lowSet[4] = '{512, 516, 518, 520};
    int hiPos[7] = '{42, 43, 250, 251, 286, 324, 326};
    int hiClr[7] = '{513, 513, 517, 517, 518, 521, 522};
    int cLo[5] = '{272, 280, 288, 128, 160};
    int cW[5] = '{8, 6, 16, 32, 32};
    int cClr[5] = '{518, 518, 519, 514, 515};
    int lvPos[8] = '{48, 15, 223, 319, 268, 325, 435, 436};
    pcv_user_model model_u (.clk(clk), .configVector(cfg));
    pcv_config_status dut_u (.clk(clk), .rst_n(rst_n), .configVector(cfg),
        .pmaLinkUp(lowIn[0]), .pcsLinkUp(lowIn[1]), .blockLock(lowIn[2]), .anLinkUp(lowIn[3]),
        .pmaRxFault(hiIn[0]), .pmaTxFault(hiIn[1]), .pcsRxFault(hiIn[2]),
        .pcsTxFault(hiIn[3]), .highBer(hiIn[4]), .anRemoteFault(hiIn[5]), .anPageRx(hiIn[6]),
        .erroredBlockEvt(evt[0]), .berEvt(evt[1]), .testPatErrEvt(evt[2]),
        .fecCorrEvt(evt[3]), .fecUncorrEvt(evt[4]), .sigDetect(lvl[0]),
        .pmaResetBusy(lvl[1]), .pcsResetBusy(lvl[2]), .anResetBusy(lvl[3]),
        .rxLinkUp(lvl[4]), .anComplete(lvl[5]), .krNegotiated(lvl[6]),
        .fecNegotiated(lvl[7]), .statusVector(sts), .anAdvPage(adv), .anXnpPage(xnp),
        .lpCoeffUpdate(lpcUpd), .lpCoeffInit(lpcInit), .lpCoeffPreset(lpcPre));
    // One clock serves both management and core logic.
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    task step(input integer c);
        repeat (c) @(negedge clk);
    endtask
    task chk(input [63:0] got, input [63:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Counters stop at all ones instead of wrapping.
    function [63:0] cnt_exp(input integer c, input integer w);
        cnt_exp = (c >= (64'h1 << w)) ? (64'h1 << w) - 64'h1 : c;
    endfunction
    function [63:0] fld(input integer k);
        fld = (sts >> cLo[k]) & ((64'h1 << cW[k]) - 64'h1);
    endfunction
    task finish_test;
        $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(100 * 20000);
        n_mismatch = n_mismatch + 1;
        finish_test;
    end
    // --------
    // Tests
    // --------
    initial begin
        rst_n = 1'h0;
        lowIn = 4'hF;
        hiIn = 7'h0;
        evt = 5'h0;
        lvl = 8'h0;
        pg = $urandom(32'hCC0700C9);
        step(10);
        rst_n = 1'h1;
        step(4);
        for (i = 0; i < 4; i++) begin
            lowIn[i] = 1'h0;
            model_u.pulse(lowSet[i]);
            step(2);
            chk(sts[lowPos[i]], 0);
            lowIn[i] = 1'h1;
            step(3);
            chk(sts[lowPos[i]], 0);
            model_u.pulse(lowSet[i]);
            step(2);
            chk(sts[lowPos[i]], 1);
        end
        for (i = 0; i < 7; i++) begin
            hiIn[i] = 1'h1;
            step(1);
            hiIn[i] = 1'h0;
            step(3);
            chk(sts[hiPos[i]], 1);
            if (i < 4) chk(sts[i < 2 ? 23 : 231], 1);
            model_u.pulse(hiClr[i]);
            step(2);
            chk(sts[hiPos[i]], 0);
            if (i < 4) chk(sts[i < 2 ? 23 : 231], 0);
        end
        for (i = 0; i < 5; i++) begin
            n = (i == 1) ? 70 : 1 + $urandom % 40;
            evt[i] = 1'h1;
            step(n);
            evt[i] = 1'h0;
            step(3);
            chk(fld(i), cnt_exp(n, cW[i]));
            model_u.pulse(cClr[i]);
            step(2);
            chk(fld(i), 0);
        end
        for (i = 0; i < 2; i++) begin
            pg = {$urandom, $urandom};
            if (i == 0) pg[47:43] = 5'h0;
            model_u.put(i ? 336 : 293, i ? 48 : 43, pg);
            step(2);
            chk(i ? xnp : adv, 0);
            model_u.pulse(i ? 524 : 523);
            step(1);
            chk(i ? xnp : adv, pg);
            model_u.put(i ? 336 : 293, i ? 48 : 43, ~pg);
            step(3);
            chk(i ? xnp : adv, pg);
        end
        model_u.put(65, 1, 48'h1); // FEC enable stays low while passing is enabled
        model_u.put(33, 1, 48'h1);
        model_u.put(60, 2, 48'h3);
        model_u.put(48, 6, 48'h2A);
        step(2);
        chk({lpcPre, lpcInit, lpcUpd}, 8'h2A);
        model_u.put(33, 1, 48'h0);
        step(2);
        chk({lpcPre, lpcInit}, 2'h3);
        chk({sts[109:108], sts[101:96]}, 8'hEA);
        repeat (8) begin
            lvl = $urandom;
            step(2);
            for (i = 0; i < 8; i++) chk(sts[lvPos[i]], lvl[i]);
        end
        finish_test;
    end
endmodule // testbench
